//--- rtl/dmac_buf.sv
module dmac_buf
	import dmac_pkg::*;
(
	// Clock and reset
	input wire logic  pclk,
	input wire logic  presetn,
	// Burst store
	dmac_buf_if.store bif
);

	dmac_dw_t mem [8];
	dmac_dw_t rd_data_ff;

	always_ff @(posedge pclk) begin
		if (bif.wr_en) begin
			mem[bif.wr_slot] <= bif.wr_data;
		end
	end

	// Registered read: one cycle from slot to data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data_ff <= 64'h0000_0000_0000_0000;
		end else begin
			rd_data_ff <= mem[bif.rd_slot];
		end
	end

	assign bif.rd_data = rd_data_ff;

endmodule

//--- rtl/dmac_buf_if.sv
interface dmac_buf_if;
	import dmac_pkg::*;
	logic       wr_en;
	logic [2:0] wr_slot;
	dmac_dw_t   wr_data;
	logic [2:0] rd_slot;
	dmac_dw_t   rd_data;

	modport owner (output wr_en, output wr_slot, output wr_data, output rd_slot, input rd_data);
	modport store (input wr_en, input wr_slot, input wr_data, input rd_slot, output rd_data);
endinterface

//--- rtl/dmac_defines.svh
`ifndef DMAC_DEFINES_SVH
`define DMAC_DEFINES_SVH

// Channel window: channel n at n * CH_STRIDE, register index in paddr[4:2]
`define DMAC_CH_STRIDE      12'h020
`define DMAC_CH_LIMIT       12'h080
`define DMAC_IDX_SRC        3'h0
`define DMAC_IDX_DST        3'h1
`define DMAC_IDX_CNT        3'h2
`define DMAC_IDX_SSTEP      3'h3
`define DMAC_IDX_DSTEP      3'h4
`define DMAC_IDX_CTRL       3'h5
`define DMAC_IDX_STAT       3'h6
`define DMAC_IDX_CHAIN      3'h7
`define DMAC_OFF_MASTER     12'h080
`define DMAC_OFF_FILL_LO    12'h084
`define DMAC_OFF_FILL_HI    12'h088

// Channel control fields
`define DMAC_CTL_ACTIVE     0
`define DMAC_CTL_EXTREQ     1
`define DMAC_CTL_SADDR      2
`define DMAC_CTL_EDGE       3
`define DMAC_CTL_BIGEND     4
`define DMAC_CTL_MEM2IO     5
`define DMAC_CTL_WID_LO     6
`define DMAC_CTL_WID_HI     7
`define DMAC_CTL_MASK       32'h0000_00FF

// Channel status fields
`define DMAC_STA_DONE       0
`define DMAC_STA_BUSY       1

// Master control fields
`define DMAC_MST_ENABLE     0
`define DMAC_MST_FIXED      1
`define DMAC_MST_MASK       32'h0000_0003

`define DMAC_RST_WORD       32'h0000_0000
`define DMAC_RST_CNT        26'h000_0000
`define DMAC_RST_STEP       24'h00_0008

// Burst limit in double words and the byte size of one double word
`define DMAC_BURST_MAX      4'h8
`define DMAC_DW_BYTES       26'h000_0008
`define DMAC_BURST_BYTES    26'h000_0040

// Bus access sizes
`define DMAC_SIZE_BYTE      2'h0
`define DMAC_SIZE_HALF      2'h1
`define DMAC_SIZE_WORD      2'h2
`define DMAC_SIZE_DWORD     2'h3

`endif

//--- rtl/dmac_pkg.sv
package dmac_pkg;

	typedef enum logic [1:0] {
		DMAC_IDLE,
		DMAC_READ,
		DMAC_WPREP,
		DMAC_WRITE
	} dmac_state_t;

	typedef logic [25:0] dmac_cnt_t;
	typedef logic [23:0] dmac_step_t;
	typedef logic [63:0] dmac_dw_t;

endpackage

//--- rtl/dmac_top.sv
// Function
// - Separation direction low during active external reads
// - Four channels, each with own registers
// - Copy bursts up to eight double words
// - Fill writes shared fill value repeatedly
// - Signed 24-bit steps added per transfer
// - 26-bit byte count tracks remaining length
// - Round robin or fixed priority arbitration
// - Per-channel big or little endian
// - External request bit selects I/O or memory
// - Memory mode copies or fills, no request
// - I/O widths of 8, 16, 32 bits
// - Single-address or dual-address I/O transfers
// - Shared master control and fill registers
// - Edges before acknowledge release are ignored
`include "dmac_defines.svh"
module dmac_top
	import dmac_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// External bus master
	output logic             bus_req,
	output logic             bus_write,
	output logic      [31:0] bus_addr,
	output logic      [63:0] bus_wdata,
	output logic      [1:0]  bus_size,
	input  wire logic        bus_ack,
	input  wire logic [63:0] bus_rdata,
	output logic             bus_separate_dir_n,
	// External I/O handshake
	input  wire logic [3:0]  xfer_request,
	output logic      [3:0]  xfer_acknowledge
);

	function automatic dmac_dw_t swap_bytes(input dmac_dw_t d);
		dmac_dw_t r;
		r = 64'h0;
		for (int b = 0; b < 8; b++) begin
			r[8*b +: 8] = d[8*(7-b) +: 8];
		end
		return r;
	endfunction

	// Returns {found, index}; fixed scans from 0, round robin from after last
	function automatic logic [2:0] arb_pick(input logic [3:0] req, input logic [1:0] last,
		input logic fixed);
		logic [2:0] r;
		logic [1:0] idx;
		r = 3'h0;
		for (int k = 3; k >= 0; k--) begin
			idx = fixed ? 2'(k) : 2'(last + 2'(k) + 2'h1);
			if (req[idx]) begin
				r = {1'b1, idx};
			end
		end
		return r;
	endfunction

	function automatic dmac_cnt_t min_cnt(input dmac_cnt_t a, input dmac_cnt_t b);
		return (a < b) ? a : b;
	endfunction

	// Per-channel register sets, then the shared master and fill registers
	logic [31:0] src_ff   [4];
	logic [31:0] dst_ff   [4];
	dmac_cnt_t   cnt_ff   [4];
	dmac_step_t  sstep_ff [4];
	dmac_step_t  dstep_ff [4];
	logic [31:0] ctrl_ff  [4];
	logic [31:0] chain_ff [4];
	logic [3:0]  done_ff;
	logic [31:0] master_ff;
	dmac_dw_t    fill_ff;

	dmac_state_t state_ff;
	logic [1:0]  cur_ff;
	logic [1:0]  last_ff;
	logic [3:0]  beats_ff;
	logic [3:0]  beat_ff;
	logic [3:0]  req_prev_ff;
	logic [3:0]  edge_pend_ff;

	dmac_buf_if bif ();

	dmac_buf u_buf (
		.pclk    (pclk),
		.presetn (presetn),
		.bif     (bif)
	);

	// APB decode: one wait state, answer from registers
	wire        apb_acc   = psel && penable && !pready;
	wire        apb_wr    = psel && penable && pready && pwrite && !pslverr;
	wire        in_ch     = paddr < `DMAC_CH_LIMIT;
	wire [1:0]  a_ch      = paddr[6:5];
	wire [2:0]  a_idx     = paddr[4:2];
	wire        a_master  = paddr == `DMAC_OFF_MASTER;
	wire        a_fill_lo = paddr == `DMAC_OFF_FILL_LO;
	wire        a_fill_hi = paddr == `DMAC_OFF_FILL_HI;
	wire        a_mapped  = (in_ch || a_master || a_fill_lo || a_fill_hi) && paddr[1:0] == 2'h0;

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = `DMAC_RST_WORD;
		if (in_ch) begin
			unique case (a_idx)
				`DMAC_IDX_SRC:   rd_mux = src_ff[a_ch];
				`DMAC_IDX_DST:   rd_mux = dst_ff[a_ch];
				`DMAC_IDX_CNT:   rd_mux = {6'h00, cnt_ff[a_ch]};
				`DMAC_IDX_SSTEP: rd_mux = {{8{sstep_ff[a_ch][23]}}, sstep_ff[a_ch]};
				`DMAC_IDX_DSTEP: rd_mux = {{8{dstep_ff[a_ch][23]}}, dstep_ff[a_ch]};
				`DMAC_IDX_CTRL:  rd_mux = ctrl_ff[a_ch];
				`DMAC_IDX_STAT:  rd_mux = {30'h0, ctrl_ff[a_ch][`DMAC_CTL_ACTIVE], done_ff[a_ch]};
				`DMAC_IDX_CHAIN: rd_mux = chain_ff[a_ch];
			endcase
		end else if (a_master) begin
			rd_mux = master_ff;
		end else if (a_fill_lo) begin
			rd_mux = fill_ff[31:0];
		end else if (a_fill_hi) begin
			rd_mux = fill_ff[63:32];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `DMAC_RST_WORD;
		end else begin
			pready  <= apb_acc;
			pslverr <= apb_acc && !a_mapped;
			prdata  <= (apb_acc && a_mapped && !pwrite) ? rd_mux : `DMAC_RST_WORD;
		end
	end

	// Current channel fields
	wire [31:0] cctl     = ctrl_ff[cur_ff];
	wire        c_extreq = cctl[`DMAC_CTL_EXTREQ];
	wire        c_saddr  = cctl[`DMAC_CTL_SADDR];
	wire        c_fill   = !c_extreq && c_saddr;
	wire        c_mem2io = cctl[`DMAC_CTL_MEM2IO];
	wire        c_bigend = cctl[`DMAC_CTL_BIGEND];
	wire [1:0]  c_wid    = cctl[`DMAC_CTL_WID_HI:`DMAC_CTL_WID_LO];
	wire [1:0]  c_size   = !c_extreq ? `DMAC_SIZE_DWORD :
		(c_wid == 2'h0 ? `DMAC_SIZE_BYTE : c_wid == 2'h1 ? `DMAC_SIZE_HALF : `DMAC_SIZE_WORD);
	wire dmac_cnt_t c_unit = !c_extreq ? `DMAC_DW_BYTES : (dmac_cnt_t'(1) << c_size);
	wire dmac_cnt_t c_dec  = min_cnt(cnt_ff[cur_ff], c_unit);

	// Requests: memory channels need none; I/O channels need a detected request
	logic [3:0] ch_ready;
	logic [3:0] edge_seen;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			edge_seen[i] = xfer_request[i] && !req_prev_ff[i] && !xfer_acknowledge[i];
			ch_ready[i]  = ctrl_ff[i][`DMAC_CTL_ACTIVE] && cnt_ff[i] != `DMAC_RST_CNT &&
				(!ctrl_ff[i][`DMAC_CTL_EXTREQ] ||
				(ctrl_ff[i][`DMAC_CTL_EDGE] ? edge_pend_ff[i] :
				xfer_request[i] && !xfer_acknowledge[i]));
		end
	end

	wire [2:0] pick  = arb_pick(ch_ready, last_ff, master_ff[`DMAC_MST_FIXED]);
	wire       grant = state_ff == DMAC_IDLE && master_ff[`DMAC_MST_ENABLE] && pick[2];
	wire [1:0] g_ch  = pick[1:0];

	// Burst length: up to eight double words in memory mode, one unit otherwise
	wire [25:0] g_cnt   = cnt_ff[g_ch];
	wire [3:0]  g_beats = (ctrl_ff[g_ch][`DMAC_CTL_EXTREQ] || g_cnt >= `DMAC_BURST_BYTES) ?
		(ctrl_ff[g_ch][`DMAC_CTL_EXTREQ] ? 4'h1 : `DMAC_BURST_MAX) :
		4'((g_cnt + 26'h7) >> 3);

	wire beat_ack  = bus_req && bus_ack;
	wire last_beat = beat_ff == beats_ff - 4'h1;
	wire rd_done   = state_ff == DMAC_READ && beat_ack;
	wire wr_done   = state_ff == DMAC_WRITE && beat_ack;
	// Single-address I/O finishes on its one access, whatever its direction
	wire single_io = c_extreq && c_saddr;
	wire unit_done = (single_io && (rd_done || wr_done)) || (!single_io && wr_done);
	wire upd_src   = rd_done || (wr_done && c_fill) || (single_io && wr_done);
	wire upd_dst   = wr_done && !c_fill && !single_io;
	wire finish    = unit_done && last_beat;
	wire ch_empty  = cnt_ff[cur_ff] == c_dec;

	wire [31:0] s_step = {{8{sstep_ff[cur_ff][23]}}, sstep_ff[cur_ff]};
	wire [31:0] d_step = {{8{dstep_ff[cur_ff][23]}}, dstep_ff[cur_ff]};

	// Data for the write beat: fill value or buffered read data
	wire dmac_dw_t wr_src  = c_fill ? fill_ff : bif.rd_data;
	wire dmac_dw_t wr_data = c_bigend ? swap_bytes(wr_src) : wr_src;

	assign bif.wr_en   = rd_done && !single_io;
	assign bif.wr_slot = beat_ff[2:0];
	assign bif.wr_data = bus_rdata;
	assign bif.rd_slot = beat_ff[2:0];

	// Register file: a running channel's own updates win over software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				src_ff[i]   <= `DMAC_RST_WORD;
				dst_ff[i]   <= `DMAC_RST_WORD;
				cnt_ff[i]   <= `DMAC_RST_CNT;
				sstep_ff[i] <= `DMAC_RST_STEP;
				dstep_ff[i] <= `DMAC_RST_STEP;
				ctrl_ff[i]  <= `DMAC_RST_WORD;
				chain_ff[i] <= `DMAC_RST_WORD;
			end
			done_ff   <= 4'h0;
			master_ff <= `DMAC_RST_WORD;
			fill_ff   <= 64'h0000_0000_0000_0000;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (apb_wr && in_ch && a_ch == 2'(i)) begin
					unique case (a_idx)
						`DMAC_IDX_SRC:   src_ff[i]   <= pwdata;
						`DMAC_IDX_DST:   dst_ff[i]   <= pwdata;
						`DMAC_IDX_CNT:   cnt_ff[i]   <= pwdata[25:0];
						`DMAC_IDX_SSTEP: sstep_ff[i] <= pwdata[23:0];
						`DMAC_IDX_DSTEP: dstep_ff[i] <= pwdata[23:0];
						`DMAC_IDX_CTRL:  ctrl_ff[i]  <= pwdata & `DMAC_CTL_MASK;
						`DMAC_IDX_STAT:  done_ff[i]  <= done_ff[i] && !pwdata[`DMAC_STA_DONE];
						`DMAC_IDX_CHAIN: chain_ff[i] <= pwdata;
					endcase
				end
			end
			if (upd_src) begin
				src_ff[cur_ff] <= src_ff[cur_ff] + s_step;
			end
			if (upd_dst) begin
				dst_ff[cur_ff] <= dst_ff[cur_ff] + d_step;
			end
			if (unit_done) begin
				cnt_ff[cur_ff] <= cnt_ff[cur_ff] - c_dec;
			end
			if (unit_done && ch_empty) begin
				ctrl_ff[cur_ff][`DMAC_CTL_ACTIVE] <= 1'b0;
				done_ff[cur_ff] <= 1'b1;
			end
			if (apb_wr && a_master) begin
				master_ff <= pwdata & `DMAC_MST_MASK;
			end
			if (apb_wr && a_fill_lo) begin
				fill_ff[31:0] <= pwdata;
			end
			if (apb_wr && a_fill_hi) begin
				fill_ff[63:32] <= pwdata;
			end
		end
	end

	// Edge requests latch only while acknowledge is released; grant consumes them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_prev_ff  <= 4'h0;
			edge_pend_ff <= 4'h0;
		end else begin
			req_prev_ff <= xfer_request;
			for (int i = 0; i < 4; i++) begin
				if (edge_seen[i]) begin
					edge_pend_ff[i] <= 1'b1;
				end else if (grant && g_ch == 2'(i)) begin
					edge_pend_ff[i] <= 1'b0;
				end
			end
		end
	end

	// Transfer sequencer: channel kept until its burst completes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= DMAC_IDLE;
			cur_ff   <= 2'h0;
			last_ff  <= 2'h3;
			beats_ff <= 4'h0;
			beat_ff  <= 4'h0;
		end else begin
			unique case (state_ff)
				DMAC_IDLE: begin
					if (grant) begin
						cur_ff   <= g_ch;
						last_ff  <= g_ch;
						beats_ff <= g_beats;
						beat_ff  <= 4'h0;
						state_ff <= (!ctrl_ff[g_ch][`DMAC_CTL_EXTREQ] &&
							ctrl_ff[g_ch][`DMAC_CTL_SADDR]) ? DMAC_WPREP : DMAC_READ;
					end
				end
				DMAC_READ: begin
					if (rd_done && single_io) begin
						state_ff <= DMAC_IDLE;
					end else if (rd_done) begin
						beat_ff  <= last_beat ? 4'h0 : beat_ff + 4'h1;
						state_ff <= last_beat ? DMAC_WPREP : DMAC_READ;
					end
				end
				DMAC_WPREP: state_ff <= DMAC_WRITE;
				DMAC_WRITE: begin
					if (wr_done) begin
						beat_ff  <= beat_ff + 4'h1;
						state_ff <= last_beat ? DMAC_IDLE : DMAC_WPREP;
					end
				end
			endcase
		end
	end

	// Bus request: single-address I/O does one access, its direction from mem2io
	wire        go_read  = grant ? 1'b0 : (state_ff == DMAC_READ && !bus_req);
	wire        go_write = state_ff == DMAC_WRITE && !bus_req;
	wire        s_rd_dir = single_io ? c_mem2io : 1'b1;
	wire [31:0] rd_addr  = src_ff[cur_ff];
	wire [31:0] wr_addr  = (c_fill || single_io) ? src_ff[cur_ff] : dst_ff[cur_ff];
	wire        hold_req = bus_req && !bus_ack;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_req   <= 1'b0;
			bus_write <= 1'b0;
			bus_addr  <= `DMAC_RST_WORD;
			bus_wdata <= 64'h0000_0000_0000_0000;
			bus_size  <= `DMAC_SIZE_DWORD;
		end else if (hold_req) begin
			bus_req <= 1'b1;
		end else if (go_read && !beat_ack) begin
			bus_req   <= 1'b1;
			bus_write <= !s_rd_dir;
			bus_addr  <= rd_addr;
			bus_size  <= c_size;
		end else if (go_write && !beat_ack) begin
			bus_req   <= 1'b1;
			bus_write <= 1'b1;
			bus_addr  <= wr_addr;
			bus_wdata <= wr_data;
			bus_size  <= c_size;
		end else begin
			bus_req <= 1'b0;
		end
	end

	// Acknowledge spans the whole unit of an I/O channel; direction flag on reads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xfer_acknowledge   <= 4'h0;
			bus_separate_dir_n <= 1'b1;
		end else begin
			for (int i = 0; i < 4; i++) begin
				xfer_acknowledge[i] <= state_ff != DMAC_IDLE && cur_ff == 2'(i) && c_extreq &&
					!finish;
			end
			bus_separate_dir_n <= !((go_read && !beat_ack && s_rd_dir) ||
				(hold_req && !bus_write));
		end
	end

endmodule

//--- testbench/dmac_ext_model.sv
module dmac_ext_model
	import dmac_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Wait states and device start strobes
	input  wire logic [1:0]  lat,
	input  wire logic [3:0]  io_go,
	// External bus
	input  wire logic        bus_req,
	input  wire logic        bus_write,
	input  wire logic [31:0] bus_addr,
	input  wire logic [63:0] bus_wdata,
	output logic             bus_ack,
	output logic      [63:0] bus_rdata,
	// Device handshake
	input  wire logic [3:0]  xfer_acknowledge,
	output logic      [3:0]  xfer_request
);
	dmac_dw_t   mem [64];
	logic [1:0] wait_ff;
	logic [3:0] ack_seen_ff;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_ack <= 1'b0;
			bus_rdata <= 64'h0;
			wait_ff <= 2'h0;
		end else if (bus_req && !bus_ack && wait_ff == lat) begin
			bus_ack <= 1'b1;
			wait_ff <= 2'h0;
			bus_rdata <= mem[bus_addr[8:3]];
			if (bus_write) begin
				mem[bus_addr[8:3]] <= bus_wdata;
			end
		end else begin
			bus_ack <= 1'b0;
			wait_ff <= (bus_req && !bus_ack) ? wait_ff + 2'h1 : 2'h0;
			// Stale data must never pass for a valid read
			bus_rdata <= ~bus_rdata;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xfer_request <= 4'h0;
			ack_seen_ff <= 4'h0;
		end else begin
			ack_seen_ff <= xfer_acknowledge;
			// Held one cycle past acknowledge; raised only while it is low
			xfer_request <= (xfer_request & ~ack_seen_ff) | (io_go & ~xfer_acknowledge);
		end
	end
endmodule

//--- testbench/dmac_top_assertions.sv
module dmac_top_assertions (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Register side
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// External side
	input wire logic        bus_req,
	input wire logic        bus_write,
	input wire logic [31:0] bus_addr,
	input wire logic [1:0]  bus_size,
	input wire logic        bus_ack,
	input wire logic        bus_separate_dir_n,
	input wire logic [3:0]  xfer_acknowledge
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sep_dir_a: assert property (bus_separate_dir_n == !(bus_req && !bus_write))
		else $error("direction output wrong");
	req_hold_a: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr))
		else $error("access dropped early");
	req_gap_a: assert property (bus_req && bus_ack |=> !bus_req)
		else $error("no idle cycle");
	mem_dword_a: assert property (bus_req && xfer_acknowledge == 4'h0 |-> bus_size == 2'h3)
		else $error("memory access not double word");
	io_width_a: assert property (xfer_acknowledge != 4'h0 && bus_req |-> bus_size != 2'h3)
		else $error("device access too wide");
	one_grant_a: assert property ($onehot0(xfer_acknowledge))
		else $error("two channels granted");
	apb_wait_a: assert property ($rose(penable) && psel |=> pready ##1 !pready)
		else $error("register access timing");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
		else $error("read data outside access");

	cover property (bus_req && bus_ack && bus_write);
	cover property (xfer_acknowledge != 4'h0 && bus_ack);
	cover property (pready && pslverr);
endmodule

bind dmac_top dmac_top_assertions dmac_top_assertions_i (.pclk, .presetn, .psel, .penable,
	.prdata, .pready, .pslverr, .bus_req, .bus_write, .bus_addr, .bus_size, .bus_ack,
	.bus_separate_dir_n, .xfer_acknowledge);

//--- testbench/dmac_top_tb.sv
`include "dmac_defines.svh"
module dmac_top_tb
	import dmac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        bus_req, bus_write, bus_ack, bus_separate_dir_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, bus_addr, q;
	logic [63:0] bus_wdata, bus_rdata;
	logic [1:0]  bus_size, lat;
	logic [3:0]  xfer_request, xfer_acknowledge, io_go;
	int          fails, tests_run, n_rd, n_wr, run, peak;

	dmac_top dmac_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .bus_req, .bus_write, .bus_addr, .bus_wdata, .bus_size, .bus_ack,
		.bus_rdata, .bus_separate_dir_n, .xfer_request, .xfer_acknowledge);
	dmac_ext_model dmac_ext_model_i (.pclk, .presetn, .lat, .io_go, .bus_req, .bus_write,
		.bus_addr, .bus_wdata, .bus_ack, .bus_rdata, .xfer_acknowledge, .xfer_request);

	always #12.5 pclk = ~pclk;

	// Longest run of reads shows the burst length
	always @(posedge pclk) begin
		if (bus_req === 1'b1 && bus_ack === 1'b1) begin
			if (bus_write) begin
				n_wr++;
				run = 0;
			end else begin
				n_rd++;
				run++;
				peak = (run > peak) ? run : peak;
			end
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (n = 0; n < 20 && pready !== 1'b1; n++)
			@(posedge pclk);
		if (n == 20) begin
			fails++;
			end_sim();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk({31'h0000_0000, err, q}, {32'h0000_0000, exp});
	endtask

	function automatic logic [11:0] ra(input int ch, input logic [2:0] idx);
		return 12'(ch * 32) + {7'h00, idx, 2'h0};
	endfunction

	task automatic wait_done(input int ch);
		int n;
		for (n = 0; n < 100; n++) begin
			apb(1'b0, ra(ch, `DMAC_IDX_STAT), 32'h0000_0000);
			if (q[`DMAC_STA_DONE] === 1'b1) break;
		end
		if (n == 100) begin
			fails++;
			end_sim();
		end
		rd(ra(ch, `DMAC_IDX_CNT), 32'h0000_0000);
	endtask

	task automatic wait_ack(input logic [3:0] m, input logic v);
		int n;
		for (n = 0; n < 50 && (|(xfer_acknowledge & m)) !== v; n++)
			@(posedge pclk);
		if (n == 50) begin
			fails++;
			end_sim();
		end
	endtask

	task automatic t_regs();
		rd(ra(0, `DMAC_IDX_SSTEP), 32'h0000_0008);
		wr(ra(3, `DMAC_IDX_CNT), 32'hFFFF_FFFF);
		rd(ra(3, `DMAC_IDX_CNT), 32'h03FF_FFFF);
		wr(ra(2, `DMAC_IDX_DSTEP), 32'hFF7F_FFFF);
		rd(ra(2, `DMAC_IDX_DSTEP), 32'h007F_FFFF);
		rd(ra(1, `DMAC_IDX_DSTEP), 32'h0000_0008);
		wr(ra(3, `DMAC_IDX_CNT), 32'h0000_0000);
		wr(ra(2, `DMAC_IDX_DSTEP), 32'h0000_0008);
		wr(`DMAC_OFF_FILL_HI, 32'h5566_7788);
		rd(`DMAC_OFF_FILL_HI, 32'h5566_7788);
		apb(1'b1, 12'h08C, 32'h0000_0001);
		chk(64'(err), 64'h1);
	endtask

	// Nine double words: a full burst of eight, then one
	task automatic t_copy();
		for (int i = 0; i < 9; i++)
			dmac_ext_model_i.mem[i] = 64'hC0DE_0000_0000_0000 | 64'(i);
		lat <= 2'h2;
		wr(`DMAC_OFF_MASTER, 32'h0000_0001);
		wr(ra(0, `DMAC_IDX_DST), 32'h0000_0100);
		wr(ra(0, `DMAC_IDX_CNT), 32'h0000_0048);
		wr(ra(0, `DMAC_IDX_CTRL), 32'h0000_0001);
		wait_done(0);
		for (int i = 0; i < 9; i++)
			chk(dmac_ext_model_i.mem[32 + i], 64'hC0DE_0000_0000_0000 | 64'(i));
		chk(64'(peak), 64'h8);
		rd(ra(0, `DMAC_IDX_SRC), 32'h0000_0048);
	endtask

	// Descending fill, big endian
	task automatic t_fill();
		dmac_ext_model_i.mem[60] = 64'h0;
		lat <= 2'h0;
		wr(`DMAC_OFF_FILL_LO, 32'h1122_3344);
		wr(ra(2, `DMAC_IDX_SRC), 32'h0000_01F8);
		wr(ra(2, `DMAC_IDX_SSTEP), 32'hFFFF_FFF8);
		wr(ra(2, `DMAC_IDX_CNT), 32'h0000_0018);
		wr(ra(2, `DMAC_IDX_CTRL), 32'h0000_0015);
		wait_done(2);
		for (int i = 61; i < 64; i++)
			chk(dmac_ext_model_i.mem[i], 64'h4433_2211_8877_6655);
		chk(dmac_ext_model_i.mem[60], 64'h0);
		rd(ra(2, `DMAC_IDX_SRC), 32'h0000_01E0);
	endtask

	// Two devices ask together under fixed priority; last grant was 2, but fixed priority picks 2 over 3
	task automatic t_io();
		wr(`DMAC_OFF_MASTER, 32'h0000_0003);
		wr(ra(2, `DMAC_IDX_SRC), 32'h0000_0040);
		wr(ra(2, `DMAC_IDX_CNT), 32'h0000_0004);
		wr(ra(2, `DMAC_IDX_CTRL), 32'h0000_00A7);
		wr(ra(3, `DMAC_IDX_CNT), 32'h0000_0001);
		wr(ra(3, `DMAC_IDX_CTRL), 32'h0000_0027);
		@(posedge pclk);
		io_go <= 4'hC;
		@(posedge pclk);
		io_go <= 4'h0;
		wait_ack(4'hF, 1'b1);
		chk(64'(xfer_acknowledge), 64'h4);
		wait_done(2);
		wait_done(3);
		chk(64'(n_rd), 64'hB);
		chk(64'(n_wr), 64'hC);
		rd(ra(2, `DMAC_IDX_SRC), 32'h0000_0038);
	endtask

	// Edge requests, dual address, half-word device: one unit per edge
	task automatic t_edge();
		dmac_ext_model_i.mem[16] = 64'hA5A5_0000_0000_0016;
		dmac_ext_model_i.mem[17] = 64'hA5A5_0000_0000_0017;
		wr(ra(0, `DMAC_IDX_STAT), 32'h0000_0001);
		rd(ra(0, `DMAC_IDX_STAT), 32'h0000_0000);
		wr(ra(0, `DMAC_IDX_SRC), 32'h0000_0080);
		wr(ra(0, `DMAC_IDX_DST), 32'h0000_0180);
		wr(ra(0, `DMAC_IDX_CNT), 32'h0000_0004);
		wr(ra(0, `DMAC_IDX_CTRL), 32'h0000_004B);
		for (int u = 0; u < 2; u++) begin
			@(posedge pclk);
			io_go <= 4'h1;
			@(posedge pclk);
			io_go <= 4'h0;
			wait_ack(4'h1, 1'b1);
			wait_ack(4'h1, 1'b0);
			rd(ra(0, `DMAC_IDX_CNT), 32'(2 - 2 * u));
		end
		wait_done(0);
		chk(dmac_ext_model_i.mem[48], 64'hA5A5_0000_0000_0016);
		chk(dmac_ext_model_i.mem[49], 64'hA5A5_0000_0000_0017);
		rd(ra(0, `DMAC_IDX_DST), 32'h0000_0190);
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		lat = 2'h0;
		io_go = 4'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_copy();
		t_fill();
		t_io();
		t_edge();
		end_sim();
	end
endmodule
